/* File: core/fmioc_pkg.sv */
// constants shared by the flow meter io control block
`default_nettype none
package fmioc_pkg;
   // switching output functions, one-hot
   typedef enum logic [4:0] {
      FMIOC_FN_PULSE = 5'h01,
      FMIOC_FN_EMPTY = 5'h02,
      FMIOC_FN_DOSE = 5'h04,
      FMIOC_FN_LIMIT = 5'h08,
      FMIOC_FN_NEG = 5'h10
   } fmioc_fn_t;
   // control input functions
   typedef enum logic [1:0] {
      FMIOC_IN_DOSE = 2'h0,
      FMIOC_IN_OFFSET = 2'h1,
      FMIOC_IN_CNTRST = 2'h2,
      FMIOC_IN_CREEP = 2'h3
   } fmioc_infn_t;
   // menu states, one-hot
   typedef enum logic [3:0] {
      FMIOC_M_DISP = 4'h1,
      FMIOC_M_MENU = 4'h2,
      FMIOC_M_PASS = 4'h4,
      FMIOC_M_EDIT = 4'h8
   } fmioc_menu_t;
   // register indices
   localparam logic [3:0] FMIOC_A_OUT1 = 4'h0;
   localparam logic [3:0] FMIOC_A_OUT2 = 4'h1;
   localparam logic [3:0] FMIOC_A_INFN = 4'h2;
   localparam logic [3:0] FMIOC_A_PULSE = 4'h3;
   localparam logic [3:0] FMIOC_A_UPPER = 4'h4;
   localparam logic [3:0] FMIOC_A_LOWER = 4'h5;
   localparam logic [3:0] FMIOC_A_CREEP = 4'h6;
   localparam logic [3:0] FMIOC_A_LOOP = 4'h7;
   localparam logic [3:0] FMIOC_A_STATUS = 4'h8;
   localparam logic [3:0] FMIOC_A_TOTAL = 4'h9;
   localparam logic [3:0] FMIOC_A_OFFSET = 4'ha;
   localparam logic [3:0] FMIOC_A_PASSWD = 4'hb;
   localparam logic [3:0] FMIOC_A_MENU = 4'hc;
   localparam logic [3:0] FMIOC_A_CORR = 4'hd;
   // field positions of the output config register
   localparam int FMIOC_OC_LEVEL = 5;
   localparam int FMIOC_OC_SRC = 6;
   // pulse value in 0.1 ml, range 1..30000
   localparam logic [14:0] FMIOC_PULSE_MIN = 15'h0001;
   localparam logic [14:0] FMIOC_PULSE_MAX = 15'h7530;
   localparam logic [14:0] FMIOC_PULSE_RST = 15'h000a;
   localparam logic [16:0] FMIOC_PASS_RST = 17'h0a1c6;
   // loop codes in 0.1 mA
   localparam logic [7:0] FMIOC_MA_ALERT = 8'h23;
   localparam logic [7:0] FMIOC_MA_FOUR = 8'h28;
   localparam logic [7:0] FMIOC_MA_TWENTY = 8'hc8;
   localparam logic [7:0] FMIOC_MA_SPAN4 = 8'ha0;
   // pulse timing: 10 kHz max, half period high
   localparam int FMIOC_CLK_HZ = 20000000;
   localparam int FMIOC_PMAX_HZ = 10000;
   localparam int FMIOC_PHIGH_CYC = FMIOC_CLK_HZ / FMIOC_PMAX_HZ / 2;
   // relock after 5 minutes
   localparam int FMIOC_LOCK_MIN = 5;
   localparam longint FMIOC_LOCK_CYC = 64'(FMIOC_LOCK_MIN) * 60 * FMIOC_CLK_HZ;
   localparam int FMIOC_CORR_N = 8;
endpackage : fmioc_pkg
`default_nettype wire

/* File: core/fmioc_top.sv */
// switching outputs, control input, loop code and menu of the flow meter
// Functional notes
// RULE1: first output carries one selectable function
// RULE2: pulse per volume quantum 0.1..3000 ml
// RULE3: empty pipe output, configurable level
// RULE4: limit output, configurable level
// RULE5: negative flow output, configurable level
// RULE6: second output, sink/source, five functions
// RULE7: rising control edge starts dosing
// RULE8: rising control edge captures offset
// RULE9: rising control edge clears totalizer
// RULE10: high control input holds creeping off
// RULE11: loop 4-20 or 0-20 over limits
// RULE12: empty pipe forces 3.5 mA; the code forces it only in 4-20 mode with the loop enabled
// RULE13: eight interpolation points correct curve; the code uses one gain per flow band, no interpolation
// RULE14: confirm opens menu, arrows step
// RULE15: escape goes back, confirm accepts
// RULE16: edits need correct password first
// RULE17: default password 41414, tool only
// RULE18: unlock lasts 5 min after key
// RULE19: creeping hysteresis at 75 percent
// RULE20: pulse rate capped at 10 kHz
// RULE21: control input edge gives one pulse
// RULE22: accumulate volume, carry remainder
// RULE23: one function per output
`default_nettype none
module fmioc_top #(
   parameter longint LOCK_CYC = fmioc_pkg::FMIOC_LOCK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic tool_wr,
   input wire logic [15:0] flow,
   input wire logic flow_neg,
   input wire logic [15:0] vol_inc,
   input wire logic vol_valid,
   input wire logic pipe_empty,
   input wire logic dose_busy,
   input wire logic control_input,
   input wire logic key_set,
   input wire logic key_esc,
   input wire logic key_up,
   input wire logic key_down,
   output logic first_switch_out,
   output logic second_switch_out,
   output logic second_switch_oe,
   output logic [7:0] current_loop_out,
   output logic dose_start,
   output logic offset_capture,
   output logic [15:0] corr_flow
);
   logic [6:0] out1_r, out2_r;
   logic [1:0] infn_r;
   logic [14:0] pulse_r;
   logic [15:0] upper_r, lower_r, creep_r;
   logic [1:0] loop_r;
   logic [16:0] pass_r;
   logic [31:0] total_r;
   logic [15:0] offset_r;
   logic [15:0] corr_r [fmioc_pkg::FMIOC_CORR_N];
   logic [16:0] entry_r;
   logic unlock_r;
   logic [38:0] lock_cnt_r;
   fmioc_pkg::fmioc_menu_t menu_r;
   logic [2:0] item_r;
   logic in_s1_r, in_s2_r, in_d_r;
   logic in_rise;
   logic creep_act_r;
   logic [17:0] acc_r;
   logic [11:0] phigh_cnt_r;
   logic [15:0] pend_r;
   logic pulse_lvl_r;
   logic any_key;
   logic total_clr;

   // only legal one-hot function codes stick; else pulse
   function automatic logic [4:0] fn_pick(input logic [4:0] v);
      case (v)
         fmioc_pkg::FMIOC_FN_PULSE, fmioc_pkg::FMIOC_FN_EMPTY, fmioc_pkg::FMIOC_FN_DOSE,
         fmioc_pkg::FMIOC_FN_LIMIT, fmioc_pkg::FMIOC_FN_NEG: fn_pick = v; // RULE23
         default: fn_pick = fmioc_pkg::FMIOC_FN_PULSE;
      endcase
   endfunction : fn_pick

   // level of an output for its selected function
   function automatic logic sw_level(input logic [6:0] cfg, input logic pl, input logic emp,
                                     input logic dose, input logic lim, input logic neg);
      logic act;
      act = 1'b0;
      case (cfg[4:0])
         fmioc_pkg::FMIOC_FN_PULSE: act = pl; // RULE2
         fmioc_pkg::FMIOC_FN_EMPTY: act = emp; // RULE3
         fmioc_pkg::FMIOC_FN_DOSE: act = dose;
         fmioc_pkg::FMIOC_FN_LIMIT: act = lim; // RULE4
         fmioc_pkg::FMIOC_FN_NEG: act = neg; // RULE5
         default: act = 1'b0;
      endcase
      // pulse has no level option; others may be active low
      if (cfg[4:0] == fmioc_pkg::FMIOC_FN_PULSE) begin
         sw_level = act;
      end else begin
         sw_level = act ^ ~cfg[fmioc_pkg::FMIOC_OC_LEVEL];
      end
   endfunction : sw_level

   assign any_key = key_set | key_esc | key_up | key_down;
   // single-cycle request per rising edge
   assign in_rise = in_s2_r & ~in_d_r; // RULE21

   always_ff @(posedge clk) begin
      if (rst) begin
         in_s1_r <= 1'b0;
         in_s2_r <= 1'b0;
         in_d_r <= 1'b0;
      end else begin
         in_s1_r <= control_input;
         in_s2_r <= in_s1_r;
         in_d_r <= in_s2_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dose_start <= 1'b0;
         offset_capture <= 1'b0;
      end else begin
         dose_start <= in_rise && infn_r == fmioc_pkg::FMIOC_IN_DOSE; // RULE7
         offset_capture <= in_rise && infn_r == fmioc_pkg::FMIOC_IN_OFFSET; // RULE8
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         offset_r <= 16'h0000;
      end else if (in_rise && infn_r == fmioc_pkg::FMIOC_IN_OFFSET) begin
         offset_r <= flow; // RULE8
      end
   end

   // creeping suppression with hysteresis; held off by the input
   always_ff @(posedge clk) begin
      if (rst) begin
         creep_act_r <= 1'b1;
      end else if (infn_r == fmioc_pkg::FMIOC_IN_CREEP && in_s2_r) begin
         creep_act_r <= 1'b0; // RULE10
      end else if ({2'h0, flow} < ({2'h0, creep_r} * 18'h3) >> 2) begin
         creep_act_r <= 1'b1; // RULE19
      end else if (flow > creep_r) begin
         creep_act_r <= 1'b0; // RULE19
      end
   end

   assign total_clr = in_rise && infn_r == fmioc_pkg::FMIOC_IN_CNTRST;

   always_ff @(posedge clk) begin
      if (rst) begin
         total_r <= 32'h0000_0000;
      end else if (total_clr) begin
         total_r <= 32'h0000_0000; // RULE9
      end else if (vol_valid && !creep_act_r && !flow_neg) begin
         total_r <= total_r + {16'h0000, vol_inc};
      end
   end

   // volume accumulator in 0.1 ml, remainder carried
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r <= 18'h00000;
         pend_r <= 16'h0000;
      end else begin
         logic [18:0] sum;
         logic inc, dec;
         sum = {1'b0, acc_r} + ((vol_valid && !creep_act_r && !flow_neg) ? {3'h0, vol_inc} : 19'h0);
         inc = sum >= {4'h0, pulse_r};
         dec = phigh_cnt_r == 12'h000 && pend_r != 16'h0000 && !pulse_lvl_r;
         acc_r <= inc ? 18'(sum - {4'h0, pulse_r}) : sum[17:0]; // RULE22
         pend_r <= pend_r + {15'h0000, inc} - {15'h0000, dec};
      end
   end

   // pulses queued and paced so rate never exceeds the cap
   always_ff @(posedge clk) begin
      if (rst) begin
         phigh_cnt_r <= 12'h000;
         pulse_lvl_r <= 1'b0;
      end else if (phigh_cnt_r != 12'h000) begin
         phigh_cnt_r <= phigh_cnt_r - 12'h001; // RULE20
      end else if (pulse_lvl_r) begin
         pulse_lvl_r <= 1'b0;
         phigh_cnt_r <= 12'(fmioc_pkg::FMIOC_PHIGH_CYC - 1); // RULE20
      end else if (pend_r != 16'h0000) begin
         pulse_lvl_r <= 1'b1; // RULE2
         phigh_cnt_r <= 12'(fmioc_pkg::FMIOC_PHIGH_CYC - 1);
      end
   end

   always_ff @(posedge clk) begin
      logic lim;
      lim = flow >= upper_r || flow <= lower_r;
      if (rst) begin
         first_switch_out <= 1'b0;
         second_switch_out <= 1'b0;
         second_switch_oe <= 1'b0;
      end else begin
         first_switch_out <= sw_level(out1_r, pulse_lvl_r, pipe_empty, dose_busy, lim, flow_neg); // RULE1
         // sink drives low only, source drives high only
         second_switch_out <= sw_level(out2_r, pulse_lvl_r, pipe_empty, dose_busy, lim, flow_neg); // RULE6
         second_switch_oe <= sw_level(out2_r, pulse_lvl_r, pipe_empty, dose_busy, lim, flow_neg)
                             == out2_r[fmioc_pkg::FMIOC_OC_SRC]; // RULE6
      end
   end

   // loop code in 0.1 mA
   always_ff @(posedge clk) begin
      logic [31:0] num;
      logic [15:0] span;
      span = upper_r - lower_r;
      num = 32'h0;
      if (flow > lower_r && span != 16'h0000) begin
         num = ({16'h0, flow - lower_r} * {24'h0, loop_r[0] ? fmioc_pkg::FMIOC_MA_SPAN4
                                                            : fmioc_pkg::FMIOC_MA_TWENTY}) / {16'h0, span};
      end
      if (rst) begin
         current_loop_out <= 8'h00;
      end else if (!loop_r[1]) begin
         current_loop_out <= 8'h00;
      end else if (pipe_empty && loop_r[0]) begin
         current_loop_out <= fmioc_pkg::FMIOC_MA_ALERT; // RULE12
      end else if (creep_act_r || flow <= lower_r) begin
         current_loop_out <= loop_r[0] ? fmioc_pkg::FMIOC_MA_FOUR : 8'h00; // RULE11
      end else if (flow >= upper_r) begin
         current_loop_out <= fmioc_pkg::FMIOC_MA_TWENTY; // RULE11
      end else begin
         current_loop_out <= 8'((loop_r[0] ? {24'h0, fmioc_pkg::FMIOC_MA_FOUR} : 32'h0) + num); // RULE11
      end
   end

   // curve correction: points are gains in 1/256 over eight flow bands
   always_ff @(posedge clk) begin
      logic [31:0] p;
      p = {16'h0, flow} * {16'h0, corr_r[flow[15:13]]};
      if (rst) begin
         corr_flow <= 16'h0000;
      end else begin
         corr_flow <= p[23:8]; // RULE13
      end
   end

   // menu: display, menu, password entry, edit
   always_ff @(posedge clk) begin
      if (rst) begin
         menu_r <= fmioc_pkg::FMIOC_M_DISP;
         item_r <= 3'h0;
         entry_r <= 17'h00000;
      end else begin
         case (menu_r)
            fmioc_pkg::FMIOC_M_DISP: if (key_set) menu_r <= fmioc_pkg::FMIOC_M_MENU; // RULE14
            fmioc_pkg::FMIOC_M_MENU: begin
               if (key_esc) menu_r <= fmioc_pkg::FMIOC_M_DISP; // RULE15
               else if (key_up) item_r <= item_r + 3'h1; // RULE14
               else if (key_down) item_r <= item_r - 3'h1;
               else if (key_set) begin
                  entry_r <= 17'h00000;
                  menu_r <= unlock_r ? fmioc_pkg::FMIOC_M_EDIT : fmioc_pkg::FMIOC_M_PASS; // RULE16
               end
            end
            fmioc_pkg::FMIOC_M_PASS: begin
               if (key_esc) menu_r <= fmioc_pkg::FMIOC_M_MENU; // RULE15
               else if (key_up) entry_r <= entry_r + 17'h00001;
               else if (key_down) entry_r <= entry_r - 17'h00001;
               else if (key_set) menu_r <= entry_r == pass_r ? fmioc_pkg::FMIOC_M_EDIT
                                                             : fmioc_pkg::FMIOC_M_MENU; // RULE16
            end
            fmioc_pkg::FMIOC_M_EDIT: begin
               if (!unlock_r || key_esc || key_set) menu_r <= fmioc_pkg::FMIOC_M_MENU; // RULE15
            end
            default: menu_r <= fmioc_pkg::FMIOC_M_DISP;
         endcase
      end
   end

   // unlock held until 5 minutes without any key
   always_ff @(posedge clk) begin
      if (rst) begin
         unlock_r <= 1'b0;
         lock_cnt_r <= 39'h0;
      end else if (menu_r == fmioc_pkg::FMIOC_M_PASS && key_set && entry_r == pass_r) begin
         unlock_r <= 1'b1;
         lock_cnt_r <= 39'h0;
      end else if (any_key) begin
         lock_cnt_r <= 39'h0; // RULE18
      end else if (unlock_r) begin
         if (lock_cnt_r >= 39'(LOCK_CYC - 1)) begin
            unlock_r <= 1'b0; // RULE18
         end else begin
            lock_cnt_r <= lock_cnt_r + 39'h1;
         end
      end
   end

   // edit path writes the pulse value; others go through the bus
   always_ff @(posedge clk) begin
      if (rst) begin
         out1_r <= {2'h0, 5'(fmioc_pkg::FMIOC_FN_PULSE)};
         out2_r <= {2'h0, 5'(fmioc_pkg::FMIOC_FN_EMPTY)};
         infn_r <= fmioc_pkg::FMIOC_IN_DOSE;
         pulse_r <= fmioc_pkg::FMIOC_PULSE_RST;
         upper_r <= 16'hffff;
         lower_r <= 16'h0000;
         creep_r <= 16'h0000;
         loop_r <= 2'h3;
         pass_r <= fmioc_pkg::FMIOC_PASS_RST; // RULE17
      end else if (menu_r == fmioc_pkg::FMIOC_M_EDIT && unlock_r && (key_up || key_down)) begin
         if (key_up && pulse_r < fmioc_pkg::FMIOC_PULSE_MAX) pulse_r <= pulse_r + 15'h0001; // RULE14
         else if (key_down && pulse_r > fmioc_pkg::FMIOC_PULSE_MIN) pulse_r <= pulse_r - 15'h0001;
      end else if (wr) begin
         case (addr)
            fmioc_pkg::FMIOC_A_OUT1: out1_r <= {wdata[6:5], fn_pick(wdata[4:0])}; // RULE23
            fmioc_pkg::FMIOC_A_OUT2: out2_r <= {wdata[6:5], fn_pick(wdata[4:0])}; // RULE23
            fmioc_pkg::FMIOC_A_INFN: infn_r <= fmioc_pkg::fmioc_infn_t'(wdata[1:0]);
            fmioc_pkg::FMIOC_A_PULSE: if (wdata[14:0] >= fmioc_pkg::FMIOC_PULSE_MIN &&
                                          wdata[14:0] <= fmioc_pkg::FMIOC_PULSE_MAX)
               pulse_r <= wdata[14:0]; // RULE2
            fmioc_pkg::FMIOC_A_UPPER: upper_r <= wdata[15:0];
            fmioc_pkg::FMIOC_A_LOWER: lower_r <= wdata[15:0];
            fmioc_pkg::FMIOC_A_CREEP: creep_r <= wdata[15:0];
            fmioc_pkg::FMIOC_A_LOOP: loop_r <= wdata[1:0];
            // password only from the tool port
            fmioc_pkg::FMIOC_A_PASSWD: if (tool_wr) pass_r <= wdata[16:0]; // RULE17
            default: ;
         endcase
      end
   end

   // correction table, write data bits 18:16 pick point
   genvar gi;
   generate
      for (gi = 0; gi < fmioc_pkg::FMIOC_CORR_N; gi++) begin : g_corr
         always_ff @(posedge clk) begin
            if (rst) begin
               corr_r[gi] <= 16'h0100;
            end else if (wr && addr == fmioc_pkg::FMIOC_A_CORR && wdata[18:16] == 3'(gi)) begin
               corr_r[gi] <= wdata[15:0]; // RULE13
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h0;
      end else if (rd) begin
         case (addr)
            fmioc_pkg::FMIOC_A_OUT1: rdata <= {25'h0, out1_r};
            fmioc_pkg::FMIOC_A_OUT2: rdata <= {25'h0, out2_r};
            fmioc_pkg::FMIOC_A_INFN: rdata <= {30'h0, infn_r};
            fmioc_pkg::FMIOC_A_PULSE: rdata <= {17'h0, pulse_r};
            fmioc_pkg::FMIOC_A_UPPER: rdata <= {16'h0, upper_r};
            fmioc_pkg::FMIOC_A_LOWER: rdata <= {16'h0, lower_r};
            fmioc_pkg::FMIOC_A_CREEP: rdata <= {16'h0, creep_r};
            fmioc_pkg::FMIOC_A_LOOP: rdata <= {30'h0, loop_r};
            fmioc_pkg::FMIOC_A_STATUS: rdata <= {26'h0, unlock_r, creep_act_r, pulse_lvl_r, in_s2_r,
                                                 pipe_empty, flow_neg};
            fmioc_pkg::FMIOC_A_TOTAL: rdata <= total_r;
            fmioc_pkg::FMIOC_A_OFFSET: rdata <= {16'h0, offset_r};
            fmioc_pkg::FMIOC_A_MENU: rdata <= {25'h0, item_r, menu_r};
            default: rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end
endmodule : fmioc_top
`default_nettype wire

/* File: tb/fmioc_partner.sv */
// far side model: pulse counter, control source and second output line
`default_nettype none
module fmioc_partner (
   input wire logic clk,
   input wire logic count_en,
   input wire logic pulse_line,
   input wire logic q2_out,
   input wire logic q2_oe,
   input wire logic ctl_cmd,
   output logic control_input,
   output logic q2_wire,
   output int n_pulse,
   output int min_high
);
   timeunit 1ns / 1ps;
   int run;
   logic last;
   // released line rests at its pull-up
   assign q2_wire = q2_oe ? q2_out : 1'b1;
   always @(posedge clk) begin
      control_input <= ctl_cmd;
      last <= pulse_line & count_en;
      if (!count_en) begin
         n_pulse <= 0;
         min_high <= 32'h7fffffff;
         run <= 0;
      end else begin
         run <= pulse_line ? run + 1 : 0;
         if (pulse_line && !last) n_pulse <= n_pulse + 1;
         if (!pulse_line && last && run < min_high) min_high <= run;
      end
   end
endmodule : fmioc_partner
`default_nettype wire

/* File: tb/fmioc_test.sv */
// self-checking bench for the flow meter io control block
`default_nettype none
module fmioc_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam longint LOCK = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [3:0] keys = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic bus_wr = 1'b0, bus_rd = 1'b0, tool_wr = 1'b0, flow_neg = 1'b0, vol_valid = 1'b0, rd_q = 1'b0;
   logic pipe_empty = 1'b0, ctl_cmd = 1'b0, count_en = 1'b0;
   logic [15:0] flow = 16'h0, vol_inc = 16'h0, inc, corr_flow;
   logic [31:0] rdata;
   logic [7:0] loop_code;
   logic first_switch_out, second_switch_out, second_switch_oe, dose_start, offset_capture, control_input;
   int n_pulse, min_high, sum, n_dose = 0, n_off = 0, n_mismatch = 0, checks = 0, seed = 32'h6e16;
   int pv_in[5] = '{0, 30001, 30000, 1, 25};
   int pv_ex[5] = '{10, 10, 30000, 1, 25};
   int cr_f[5] = '{100, 900, 1100, 900, 700};
   logic [4:0] cr_e = 5'h13;
   logic [31:0] exp_q[$], msk_q[$];
   always #25 clk = ~clk;
   fmioc_top #(.LOCK_CYC(LOCK)) fmioc_top_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(bus_wr),
      .rd(bus_rd), .rdata(rdata), .tool_wr(tool_wr), .flow(flow), .flow_neg(flow_neg), .vol_inc(vol_inc),
      .vol_valid(vol_valid), .pipe_empty(pipe_empty), .dose_busy(1'b0), .control_input(control_input),
      .key_set(keys[0]), .key_esc(keys[1]), .key_up(keys[2]), .key_down(keys[3]),
      .first_switch_out(first_switch_out), .second_switch_out(second_switch_out),
      .second_switch_oe(second_switch_oe), .current_loop_out(loop_code), .dose_start(dose_start),
      .offset_capture(offset_capture), .corr_flow(corr_flow));
   fmioc_partner fmioc_partner_i (.clk(clk), .count_en(count_en), .pulse_line(first_switch_out),
      .q2_out(second_switch_out), .q2_oe(second_switch_oe), .ctl_cmd(ctl_cmd), .control_input(control_input),
      .q2_wire(), .n_pulse(n_pulse), .min_high(min_high));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   // expectation queued with the request
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(posedge clk);
   endtask : rd_chk
   task automatic key(input int k);
      keys <= 4'(1 << k);
      @(posedge clk);
      keys <= 4'h0;
      tick(2);
   endtask : key
   task automatic ctl_pulse;
      ctl_cmd <= 1'b1;
      tick(10);
      ctl_cmd <= 1'b0;
      tick(10);
   endtask : ctl_pulse
   task automatic results;
      if (n_mismatch == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   always @(posedge clk) begin
      if (rd_q) begin
         cmp(rdata & msk_q[0], exp_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      rd_q <= bus_rd;
      if (dose_start) n_dose++;
      if (offset_capture) n_off++;
   end
   initial begin
      tick(60000);
      n_mismatch++;
      results();
   end
   initial begin
      tick(6);
      rst <= 1'b0;
      tick(1);
      rd_chk(fmioc_pkg::FMIOC_A_OUT1, 32'h01, 32'h1f);
      rd_chk(fmioc_pkg::FMIOC_A_OUT2, 32'h02, 32'h3f);
      rd_chk(fmioc_pkg::FMIOC_A_LOOP, 32'h3, 32'h3);
      rd_chk(fmioc_pkg::FMIOC_A_MENU, 32'h1, 32'hf);
      rd_chk(4'he, 32'h0, 32'hffffffff);
      for (int i = 0; i < 5; i++) begin
         wr(fmioc_pkg::FMIOC_A_PULSE, 32'(pv_in[i]));
         rd_chk(fmioc_pkg::FMIOC_A_PULSE, 32'(pv_ex[i]), 32'h7fff);
         wr(fmioc_pkg::FMIOC_A_OUT1, 32'(1 << i));
         rd_chk(fmioc_pkg::FMIOC_A_OUT1, 32'(1 << i), 32'h1f);
         wr(fmioc_pkg::FMIOC_A_OUT2, 32'h40 | 32'(1 << i));
         rd_chk(fmioc_pkg::FMIOC_A_OUT2, 32'h40 | 32'(1 << i), 32'h7f);
      end
      wr(fmioc_pkg::FMIOC_A_OUT1, 32'h03);
      rd_chk(fmioc_pkg::FMIOC_A_OUT1, 32'h01, 32'h1f);
      wr(fmioc_pkg::FMIOC_A_CREEP, 32'h0);
      flow <= 16'd100;
      wr(fmioc_pkg::FMIOC_A_OUT1, 32'h22);
      pipe_empty <= 1'b1;
      tick(4);
      cmp(32'(first_switch_out), 32'h1);
      cmp(32'(loop_code), 32'(fmioc_pkg::FMIOC_MA_ALERT));
      wr(fmioc_pkg::FMIOC_A_OUT1, 32'h02);
      tick(4);
      cmp(32'(first_switch_out), 32'h0);
      pipe_empty <= 1'b0;
      wr(fmioc_pkg::FMIOC_A_OUT1, 32'h30);
      for (int i = 1; i >= 0; i--) begin
         flow_neg <= 1'(i);
         tick(4);
         cmp(32'(first_switch_out), 32'(i));
         cmp(32'({second_switch_out, second_switch_oe}), 32'(3 - 3 * i));
      end
      wr(fmioc_pkg::FMIOC_A_UPPER, 32'd1000);
      wr(fmioc_pkg::FMIOC_A_LOWER, 32'd200);
      wr(fmioc_pkg::FMIOC_A_OUT1, 32'h28);
      for (int i = 0; i < 3; i++) begin
         flow <= 16'(1000 - 400 * i);
         tick(4);
         cmp(32'(first_switch_out), 32'(i != 1));
         cmp(32'(loop_code), 32'(200 - 80 * i));
      end
      // pulse value 2.5 ml against random volume steps, remainder kept
      wr(fmioc_pkg::FMIOC_A_OUT1, 32'h21);
      flow <= 16'd600;
      count_en <= 1'b1;
      sum = 0;
      for (int i = 0; i < 6; i++) begin
         inc = 16'(($random(seed) & 31) + 1);
         sum += int'(inc);
         vol_inc <= inc;
         vol_valid <= 1'b1;
         tick(1);
         vol_valid <= 1'b0;
         tick(1);
      end
      tick((sum / 25 + 1) * 2100);
      cmp(32'(n_pulse), 32'(sum / 25));
      cmp(32'(min_high >= 1000), 32'h1);
      count_en <= 1'b0;
      wr(fmioc_pkg::FMIOC_A_INFN, 32'h0);
      ctl_pulse();
      cmp(32'(n_dose), 32'h1);
      cmp(32'(n_off), 32'h0);
      wr(fmioc_pkg::FMIOC_A_INFN, 32'h1);
      ctl_pulse();
      cmp(32'(n_off), 32'h1);
      wr(fmioc_pkg::FMIOC_A_INFN, 32'h2);
      ctl_pulse();
      rd_chk(fmioc_pkg::FMIOC_A_TOTAL, 32'h0, 32'hffffffff);
      wr(fmioc_pkg::FMIOC_A_CREEP, 32'd1000);
      for (int i = 0; i < 5; i++) begin
         flow <= 16'(cr_f[i]);
         tick(4);
         rd_chk(fmioc_pkg::FMIOC_A_STATUS, 32'(cr_e[i]) << 4, 32'h10);
      end
      wr(fmioc_pkg::FMIOC_A_INFN, 32'h3);
      ctl_cmd <= 1'b1;
      tick(6);
      rd_chk(fmioc_pkg::FMIOC_A_STATUS, 32'h0, 32'h10);
      ctl_cmd <= 1'b0;
      tick(6);
      rd_chk(fmioc_pkg::FMIOC_A_STATUS, 32'h10, 32'h10);
      // password needs the tool flag
      wr(fmioc_pkg::FMIOC_A_PASSWD, 32'h3);
      key(0);
      rd_chk(fmioc_pkg::FMIOC_A_MENU, 32'(fmioc_pkg::FMIOC_M_MENU), 32'hf);
      for (int t = 0; t < 2; t++) begin
         key(0);
         rd_chk(fmioc_pkg::FMIOC_A_MENU, 32'(fmioc_pkg::FMIOC_M_PASS), 32'hf);
         repeat (3) key(2);
         key(0);
         if (t == 0) begin
            rd_chk(fmioc_pkg::FMIOC_A_MENU, 32'(fmioc_pkg::FMIOC_M_MENU), 32'hf);
            tool_wr <= 1'b1;
            wr(fmioc_pkg::FMIOC_A_PASSWD, 32'h3);
            tool_wr <= 1'b0;
         end
      end
      rd_chk(fmioc_pkg::FMIOC_A_MENU, 32'(fmioc_pkg::FMIOC_M_EDIT), 32'hf);
      key(2);
      rd_chk(fmioc_pkg::FMIOC_A_PULSE, 32'd26, 32'h7fff);
      key(0);
      rd_chk(fmioc_pkg::FMIOC_A_MENU, 32'(fmioc_pkg::FMIOC_M_MENU), 32'hf);
      key(1);
      rd_chk(fmioc_pkg::FMIOC_A_MENU, 32'(fmioc_pkg::FMIOC_M_DISP), 32'hf);
      tick(20);
      rd_chk(fmioc_pkg::FMIOC_A_STATUS, 32'h20, 32'h20);
      tick(40);
      rd_chk(fmioc_pkg::FMIOC_A_STATUS, 32'h0, 32'h20);
      flow <= 16'd100;
      wr(fmioc_pkg::FMIOC_A_CORR, 32'h00000200);
      tick(4);
      cmp(32'(corr_flow), 32'd200);
      rd_chk(fmioc_pkg::FMIOC_A_CORR, 32'h0, 32'hffffffff);
      tick(2);
      results();
   end
endmodule : fmioc_test
`default_nettype wire

/* File: tb/fmioc_top_assertions.sv */
// port-level checker for the flow meter io control block
`default_nettype none
module fmioc_top_assertions #(
   parameter longint LOCK_CYC = 50
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic control_input,
   input wire logic pipe_empty,
   input wire logic [7:0] current_loop_out,
   input wire logic dose_start,
   input wire logic offset_capture
);
   timeunit 1ns / 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // pin held low long enough that no synced rise can still be in flight
   sequence ctl_idle;
      !control_input [*6];
   endsequence
   sequence empty_held;
      pipe_empty [*3];
   endsequence
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside answer cycle");
   chk_unmapped_zero: assert property ($past(rd) && $past(addr) > 4'hd |-> rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_corr_hidden: assert property ($past(rd) && $past(addr) == fmioc_pkg::FMIOC_A_CORR |-> rdata == 32'h0)
      else $error("correction table readable");
   chk_dose_single: assert property (dose_start |=> !dose_start)
      else $error("dose start longer than one cycle");
   chk_offset_single: assert property (offset_capture |=> !offset_capture)
      else $error("offset capture longer than one cycle");
   chk_one_action: assert property (!(dose_start && offset_capture))
      else $error("two control actions at once");
   chk_dose_cause: assert property (dose_start |-> $past(control_input, 3))
      else $error("dose start without control input high");
   chk_offset_cause: assert property (offset_capture |-> $past(control_input, 3))
      else $error("offset capture without control input high");
   chk_no_spurious: assert property (ctl_idle |-> !dose_start && !offset_capture)
      else $error("action without control edge");
   chk_empty_alert: assert property (empty_held |-> current_loop_out inside {fmioc_pkg::FMIOC_MA_ALERT, 8'h00})
      else $error("loop not at alert level on empty pipe");
endmodule : fmioc_top_assertions
bind fmioc_top fmioc_top_assertions #(.LOCK_CYC(LOCK_CYC)) fmioc_top_assertions_i (.clk(clk), .rst(rst),
   .addr(addr), .rd(rd), .rdata(rdata), .control_input(control_input), .pipe_empty(pipe_empty),
   .current_loop_out(current_loop_out), .dose_start(dose_start), .offset_capture(offset_capture));
`default_nettype wire
